// ==== inc/tpde_consts.vh ====
// Constants for the T1 transmit pulse density enforcer.
// Assumes an AXI4-Lite register bus with 32-bit data and a 125 MHz clock.
//
// How it works
// - With insert_irq_enable set, every bit stuff raises the interrupt.
// - With bit_insert_enable set, ones are stuffed whenever density is violated.
// - With bit_insert_enable clear, PCM passes unaltered; violations flag changes.
// - Each stuff sets insert_event_flag; a register read clears flag and interrupt.
// - density_violation_now shows whether the latest PCM bit violated density.
// - While stuffing is enabled, density_violation_now stays low.
// - Each change of the violation indication sets density_change_flag; read clears.
// - Sixteen consecutive zeros set zero_run_flag; a read clears it.
// - Flags update regardless of their interrupt enables.
// - While bit_insert_enable is set, both density and zero-run flags are forced low.
// - zero_run_irq_enable gates zero-run detections onto the interrupt.
// - density_irq_enable gates violation onset and end, unless insert_irq_enable set.
// - While e1_mode_select is high, the whole register is held in reset.
`ifndef TPDE_CONSTS_VH
`define TPDE_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define TPDE_REG_INDEX 12'h069
`define TPDE_REG_ADDR 12'h1A4
`define TPDE_PCM_ADDR 12'h1A8

// ****************************************
// Field positions
// ****************************************
`define TPDE_BIT_INS_IRQ_EN 7
`define TPDE_BIT_INS_EN 6
`define TPDE_BIT_INS_FLAG 5
`define TPDE_BIT_VIOL_NOW 4
`define TPDE_BIT_ZRUN_FLAG 3
`define TPDE_BIT_DENS_FLAG 2
`define TPDE_BIT_ZRUN_IRQ_EN 1
`define TPDE_BIT_DENS_IRQ_EN 0

// ****************************************
// Reset values and counts
// ****************************************
`define TPDE_CTRL_RESET 8'h00
`define TPDE_ZERO_RUN_LEN 5'h10
`define TPDE_MAX_ZEROS 5'h0F
`define TPDE_MAX_N 23
`define TPDE_RESP_OKAY 2'h0
`define TPDE_RESP_SLVERR 2'h2

`endif

// ==== rtl/tpde_enforcer.v ====
// Transmit pulse density enforcer with an AXI4-Lite register slave.
// Assumes PCM bits arrive from framer logic on aclk with a valid strobe,
// and that e1_mode_select comes from a pin of another domain.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tpde_consts.vh"

module tpde_enforcer #(
    parameter HIST = 192
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Mode strap
    input wire e1_mode_select,
    // PCM stream in
    input wire pcm_in_valid,
    input wire pcm_in_bit,
    // PCM stream out
    output reg pcm_out_valid,
    output reg pcm_out_bit,
    // Status and interrupt
    output reg density_violation_now,
    output reg irq_out_n,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ****************************************
    // Mode synchroniser
    // ****************************************
    reg e1_meta;
    reg e1_sync;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            e1_meta <= 1'b0;
            e1_sync <= 1'b0;
        end
        else
        begin
            e1_meta <= e1_mode_select;
            e1_sync <= e1_meta;
        end
    end
    wire blk_rst = !aresetn || e1_sync;

    // ****************************************
    // Control and flags
    // ****************************************
    reg ins_irq_en;
    reg bit_insert_enable;
    reg zero_irq_en;
    reg dens_irq_en;
    reg insert_event_flag;
    reg density_change_flag;
    reg zero_run_flag;

    // ****************************************
    // Bit history and density check
    // ****************************************
    // The history holds the emitted bits, so a stuffed one counts at once.
    reg [HIST-1:0] hist;
    reg [4:0] zero_cnt;
    wire [23:0] win_short;
    reg viol_d;
    wire [HIST-1:0] hist_raw = {hist[HIST-2:0], pcm_in_bit};
    genvar n;
    generate
        for (n = 1; n <= `TPDE_MAX_N; n = n + 1)
        begin : g_win
            integer k;
            reg [7:0] ones;
            reg short_n;
            always @*
            begin
                ones = 8'h00;
                short_n = 1'b0;
                for (k = 0; k < 8 * (n + 1); k = k + 1)
                    ones = ones + {7'h00, hist_raw[k]};
                short_n = (ones < n);
            end
            assign win_short[n] = short_n;
        end
    endgenerate
    assign win_short[0] = 1'b0;

    wire zero_excess = !pcm_in_bit && (zero_cnt >= `TPDE_MAX_ZEROS);
    wire viol_raw = zero_excess || (|win_short);
    wire do_stuff = bit_insert_enable && viol_raw;
    wire out_bit = pcm_in_bit | do_stuff;
    wire viol_ind = viol_raw && !bit_insert_enable;
    wire [4:0] next_zero_cnt = out_bit ? 5'h00 :
        (zero_cnt == `TPDE_ZERO_RUN_LEN ? zero_cnt : zero_cnt + 5'h01);
    wire zero_run_hit = pcm_in_valid && !out_bit &&
        (zero_cnt == `TPDE_ZERO_RUN_LEN - 5'h01);

    always @(posedge aclk)
    begin
        if (blk_rst)
        begin
            hist <= {HIST{1'b1}};
            zero_cnt <= 5'h00;
            viol_d <= 1'b0;
            pcm_out_valid <= 1'b0;
            pcm_out_bit <= 1'b0;
            density_violation_now <= 1'b0;
        end
        else
        begin
            pcm_out_valid <= pcm_in_valid;
            if (pcm_in_valid)
            begin
                hist <= {hist[HIST-2:0], out_bit};
                zero_cnt <= next_zero_cnt;
                pcm_out_bit <= out_bit;
                viol_d <= viol_ind;
                density_violation_now <= viol_ind;
            end
            else if (bit_insert_enable)
                density_violation_now <= 1'b0;
        end
    end
    wire viol_change = pcm_in_valid && (viol_ind != viol_d);

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire wr_hit = s_axi_awaddr[11:2] == `TPDE_REG_ADDR >> 2;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;
    wire rd_hit = s_axi_araddr[11:2] == `TPDE_REG_ADDR >> 2;
    wire rd_clr = rd_go && rd_hit;
    wire [7:0] ctrl_rd = {ins_irq_en, bit_insert_enable, insert_event_flag,
        density_violation_now, zero_run_flag, density_change_flag,
        zero_irq_en, dens_irq_en};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TPDE_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `TPDE_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            s_axi_arready <= rd_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `TPDE_RESP_OKAY : `TPDE_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_hit ? `TPDE_RESP_OKAY : `TPDE_RESP_SLVERR;
                s_axi_rdata <= rd_hit ? {24'h000000, ctrl_rd} : 32'h00000000;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Register and interrupt
    // ****************************************
    // A new event in the read cycle survives the clear, so none is lost.
    always @(posedge aclk)
    begin
        if (blk_rst)
        begin
            ins_irq_en <= 1'b0;
            bit_insert_enable <= 1'b0;
            zero_irq_en <= 1'b0;
            dens_irq_en <= 1'b0;
            insert_event_flag <= 1'b0;
            density_change_flag <= 1'b0;
            zero_run_flag <= 1'b0;
            irq_out_n <= 1'b1;
        end
        else
        begin
            if (wr_go && wr_hit && s_axi_wstrb[0])
            begin
                ins_irq_en <= s_axi_wdata[`TPDE_BIT_INS_IRQ_EN];
                bit_insert_enable <= s_axi_wdata[`TPDE_BIT_INS_EN];
                zero_irq_en <= s_axi_wdata[`TPDE_BIT_ZRUN_IRQ_EN];
                dens_irq_en <= s_axi_wdata[`TPDE_BIT_DENS_IRQ_EN];
            end
            insert_event_flag <= (pcm_in_valid && do_stuff) ||
                (insert_event_flag && !rd_clr);
            if (bit_insert_enable)
            begin
                density_change_flag <= 1'b0;
                zero_run_flag <= 1'b0;
            end
            else
            begin
                density_change_flag <= viol_change ||
                    (density_change_flag && !rd_clr);
                zero_run_flag <= zero_run_hit ||
                    (zero_run_flag && !rd_clr);
            end
            irq_out_n <= !((insert_event_flag && ins_irq_en) ||
                (zero_run_flag && zero_irq_en) ||
                (density_change_flag && dens_irq_en && !ins_irq_en));
        end
    end

endmodule // tpde_enforcer

// ==== testbench/tpde_enforcer_assertions.sv ====
// Port checker for the density enforcer.
// Assumes PCM bits are spaced apart and idle around mode changes.
`timescale 1ns/1ps
`include "tpde_consts.vh"
module tpde_enforcer_assertions
(
    // Clock, reset and mode
    input wire aclk, input wire aresetn, input wire e1_mode_select,
    // Stream and status
    input wire pcm_in_valid, input wire pcm_in_bit, input wire pcm_out_valid,
    input wire pcm_out_bit, input wire density_violation_now,
    input wire irq_out_n,
    // Register bus
    input wire s_axi_awvalid, input wire s_axi_wvalid, input wire s_axi_awready,
    input wire s_axi_wready, input wire s_axi_bvalid, input wire s_axi_arvalid,
    input wire [11:0] s_axi_araddr, input wire s_axi_arready,
    input wire s_axi_rvalid, input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp
);
    // ****
    // Output zero run, so a missed violation is caught at the wire.
    // ****
    reg [4:0] zc;
    always @(posedge aclk)
    begin
        if (!aresetn || e1_mode_select)
            zc <= 5'h00;
        else if (pcm_out_valid)
            zc <= pcm_out_bit ? 5'h00 : zc + {4'h0, zc != 5'h1F};
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wtake; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
    sequence s_rtake; s_axi_arvalid && !s_axi_rvalid; endsequence
    property p_outv; pcm_in_valid |=> pcm_out_valid; endproperty
    a_outv: assert property (p_outv) else $error("bit lost");
    property p_gap; !pcm_in_valid |=> !pcm_out_valid; endproperty
    a_gap: assert property (p_gap) else $error("extra bit");
    property p_viol; pcm_in_valid && !pcm_in_bit && zc >= 5'h0F
        |=> density_violation_now || pcm_out_bit; endproperty
    a_viol: assert property (p_viol) else $error("run passed");
    property p_wr; s_wtake |=> s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_wr: assert property (p_wr) else $error("write not answered");
    property p_rd; s_rtake |=> s_axi_rvalid && s_axi_arready; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_err; s_rtake ##0 (s_axi_araddr != `TPDE_REG_ADDR
        && s_axi_araddr != `TPDE_PCM_ADDR) |=> s_axi_rresp == `TPDE_RESP_SLVERR
        && s_axi_rdata == 32'h00000000; endproperty
    a_err: assert property (p_err) else $error("unmapped read accepted");
    property p_e1; e1_mode_select [*4] |=> irq_out_n && !density_violation_now;
    endproperty
    a_e1: assert property (p_e1) else $error("mode reset missed");
endmodule // tpde_enforcer_assertions

// ==== testbench/tpde_pcm_src.sv ====
// Framer side model: sends a pattern, one bit every four cycles.
// Assumes the bench changes the pattern only while disabled.
`timescale 1ns/1ps
module tpde_pcm_src
(
    // Clock and control
    input wire aclk,
    input wire en,
    input wire [31:0] pat,
    // Stream out
    output reg pcm_in_valid,
    output reg pcm_in_bit
);
    // ****
    // Idle cycles toggle the data line so stale bits never look valid.
    // ****
    reg [4:0] idx = 5'h00;
    reg [1:0] ph = 2'h0;
    initial pcm_in_valid = 1'b0;
    initial pcm_in_bit = 1'b0;
    always @(posedge aclk)
    begin
        ph <= en ? ph + 2'h1 : 2'h0;
        pcm_in_valid <= en && ph == 2'h3;
        if (!en) idx <= 5'h00;
        if (en && ph == 2'h3)
        begin
            pcm_in_bit <= pat[5'h1F - idx];
            idx <= idx + 5'h01;
        end
        else
            pcm_in_bit <= ~pcm_in_bit;
    end
endmodule // tpde_pcm_src

// ==== testbench/t1_pulse_density_enforcer_tb.sv ====
// Bench for the density enforcer.
// Assumes the design, its header, checker and framer model are compiled.
`timescale 1ns/1ps
`include "tpde_consts.vh"
module t1_pulse_density_enforcer_tb;
    reg aclk = 1'b0, aresetn = 1'b0, e1 = 1'b0, en = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0, last_in = 1'b0, saw_viol = 1'b0;
    reg [11:0] araddr = 12'h000, awaddr = `TPDE_REG_ADDR;
    reg clr_mon = 1'b0;
    reg [31:0] pat = 32'h00000000, wdata = 32'h00000000, d;
    reg [1:0] r;
    wire pv, pb, ov, ob, viol, irq_n, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer fail_count = 0, num_checks = 0, zrun = 0, zmax = 0, i, stuff_on = 0;
    always #4 aclk = ~aclk;
    tpde_pcm_src u_tpde_pcm_src (.aclk(aclk), .en(en), .pat(pat),
        .pcm_in_valid(pv), .pcm_in_bit(pb));
    tpde_enforcer u_tpde_enforcer (.aclk(aclk), .aresetn(aresetn),
        .e1_mode_select(e1), .pcm_in_valid(pv), .pcm_in_bit(pb),
        .pcm_out_valid(ov), .pcm_out_bit(ob), .density_violation_now(viol),
        .irq_out_n(irq_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task tmo;
    begin
        if (i >= 200)
        begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    endtask
    task wr(input [7:0] v, input [1:0] e);
    begin
        @(posedge aclk);
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 200 && bvalid !== 1'b1; i = i + 1)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        tmo;
        chk(bresp, e);
        bready <= 1'b0;
    end
    endtask
    task rd(input [11:0] a);
    begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 200 && rvalid !== 1'b1; i = i + 1)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        tmo;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    end
    endtask
    task pcm(input [31:0] p, input integer n);
    begin
        pat <= p;
        en <= 1'b1;
        repeat (4 * n) @(posedge aclk);
        en <= 1'b0;
        repeat (8) @(posedge aclk);
    end
    endtask
    always @(posedge aclk)
    begin
        if (clr_mon)
        begin
            saw_viol <= 1'b0;
            zrun = 0;
            zmax = 0;
        end
        else
        begin
            if (viol) saw_viol <= 1'b1;
            if (ov) zrun = ob ? 0 : zrun + 1;
            if (zrun > zmax) zmax = zrun;
        end
        if (pv) last_in <= pb;
        if (ov && stuff_on == 0) chk(ob, last_in);
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TPDE_REG_ADDR);
        chk(d, 32'h00000000);
        rd(12'h000);
        chk(r, `TPDE_RESP_SLVERR);
        awaddr <= 12'h000;
        wr(8'hFF, `TPDE_RESP_SLVERR);
        awaddr <= `TPDE_REG_ADDR;
        rd(`TPDE_REG_ADDR);
        chk(d, 32'h00000000);
        wr(8'h03, `TPDE_RESP_OKAY);
        pcm(32'h00000000, 24);
        chk(saw_viol, 1'b1);
        chk(irq_n, 1'b0);
        rd(`TPDE_REG_ADDR);
        chk({d[31:5], d[3:0]}, 32'h0000000F);
        repeat (3) @(posedge aclk);
        chk(irq_n, 1'b1);
        wr(8'h00, `TPDE_RESP_OKAY);
        pcm(32'hFFFF0000, 32);
        chk(irq_n, 1'b1);
        rd(`TPDE_REG_ADDR);
        chk(d[3:2], 2'b11);
        stuff_on = 1;
        wr(8'hC0, `TPDE_RESP_OKAY);
        repeat (2) @(posedge aclk);
        clr_mon <= 1'b1;
        @(posedge aclk);
        clr_mon <= 1'b0;
        pcm(32'h00000000, 40);
        chk(saw_viol, 1'b0);
        chk(zmax < 16, 1'b1);
        chk(irq_n, 1'b0);
        rd(`TPDE_REG_ADDR);
        chk(d[7:2], 6'b111000);
        rd(`TPDE_REG_ADDR);
        chk(d, 32'h000000C0);
        repeat (3) @(posedge aclk);
        chk(irq_n, 1'b1);
        e1 <= 1'b1;
        repeat (8) @(posedge aclk);
        e1 <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(`TPDE_REG_ADDR);
        chk(d, 32'h00000000);
        report_and_stop;
    end
endmodule // t1_pulse_density_enforcer_tb
bind tpde_enforcer tpde_enforcer_assertions u_tpde_enforcer_assertions (
    .aclk(aclk), .aresetn(aresetn), .e1_mode_select(e1_mode_select),
    .pcm_in_valid(pcm_in_valid), .pcm_in_bit(pcm_in_bit),
    .pcm_out_valid(pcm_out_valid), .pcm_out_bit(pcm_out_bit),
    .density_violation_now(density_violation_now), .irq_out_n(irq_out_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));
